// ==== hw/sfspf_pkg.sv ====
`default_nettype none

package sfspf_pkg;

    // ------------------------------------------------------------
    // Clocks
    // ------------------------------------------------------------
    localparam real SYS_CLK_HZ = 100.0e6;
    localparam real MCLK_FULL_HZ = 614400.0;
    localparam real MCLK_MID_HZ = 153600.0;
    localparam real MCLK_LOW_HZ = 76800.0;
    localparam logic [31:0] INC_FULL = 32'(longint'(MCLK_FULL_HZ * 4294967296.0 / SYS_CLK_HZ));
    localparam logic [31:0] INC_MID = 32'(longint'(MCLK_MID_HZ * 4294967296.0 / SYS_CLK_HZ));
    localparam logic [31:0] INC_LOW = 32'(longint'(MCLK_LOW_HZ * 4294967296.0 / SYS_CLK_HZ));

    // ------------------------------------------------------------
    // Codes and widths
    // ------------------------------------------------------------
    localparam logic [1:0] PM_LOW = 2'h0;
    localparam logic [1:0] PM_MID = 2'h1;
    localparam logic [1:0] PM_FULL = 2'h2;
    localparam logic [2:0] FT_FAST3 = 3'h5;
    localparam logic [2:0] FT_POST = 3'h7;
    localparam int ACC_W = 52;
    localparam int SUM_W = 58;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam logic [5:0] DISCARD = 6'h2;
    localparam logic [5:0] AVG_FULL = 6'h10;
    localparam logic [5:0] AVG_LOW = 6'h08;
    localparam logic [6:0] DEAD_MANUAL = 7'h5e;
    localparam logic [6:0] DEAD_SEQ = 7'h1e;
    localparam logic [10:0] POST_RD_FULL = 11'h020;
    localparam logic [10:0] POST_RD_MID = 11'h008;
    localparam logic [10:0] POST_RD_LOW = 11'h004;
    localparam logic [5:0] PL_27 = 6'h16;
    localparam logic [5:0] PL_25 = 6'h18;
    localparam logic [5:0] PL_20 = 6'h1e;
    localparam logic [5:0] PL_16 = 6'h24;

    function automatic logic [5:0] post_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: return PL_27;
            2'h1: return PL_25;
            2'h2: return PL_20;
            default: return PL_16;
        endcase
    endfunction

    function automatic logic [10:0] post_rd(input logic [1:0] pm);
        return (pm == PM_FULL) ? POST_RD_FULL : (pm == PM_MID) ? POST_RD_MID : POST_RD_LOW;
    endfunction

    function automatic logic [31:0] mclk_inc(input logic [1:0] pm);
        return (pm == PM_FULL) ? INC_FULL : (pm == PM_MID) ? INC_MID : INC_LOW;
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_DEAD, ST_RUN} sfspf_state_t;

endpackage

`default_nettype wire

// ==== hw/sfspf_filter.sv ====
// How it works
// - Fast settling code adds an averaging stage after sinc3; other stages unused.
// - Averaging takes 16 sinc3 outputs in full/mid power, 8 in low power.
// - Continuous fast results every (3+Avg-1)*32*rate_divider master clocks.
// - Master clock is 614.4, 153.6 or 76.8 kHz by power mode.
// - Manual channel change adds 94 master clocks before the first result.
// - Several enabled channels are cycled automatically by the sequencer.
// - Sequenced conversions after the first use a 30 cycle dead time.
// - Single channel keeps converting through input steps, undetected.
// - Sinc3 decimates by 32*rate_divider master clocks; post mode uses 32*32, 32*8 or 32*4 by power mode.
// - Averaging places notches at the sinc notch divided by Avg.
// - Post filter mode filters the sinc3 output stream by post_sel.
// - Post filters give 27.27, 25, 20 or 16.67 samples per second.
// - Post single channel: first result fully settled, then every output period.
// - Post mode with several channels settles fully on every channel.
`timescale 1ns/1ns
`default_nettype none

module sfspf_filter #(
    parameter int NCH = 16,
    parameter int CH_W = 4,
    parameter int MCLK_SCALE = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Modulator stream
    input wire logic mod_bit,
    output logic mod_take,
    // Configuration
    input wire logic [2:0] filt_type,
    input wire logic [1:0] post_sel,
    input wire logic [1:0] power_mode,
    input wire logic [10:0] rate_divider,
    input wire logic [NCH-1:0] chan_en,
    // Status and result
    output logic busy,
    output logic [CH_W-1:0] cur_chan,
    output logic res_valid,
    output logic [sfspf_pkg::SUM_W-1:0] res_data,
    output logic [CH_W-1:0] res_chan
);

    localparam int CFG_W = 3 + 2 + 2 + 11 + NCH;
    localparam int ACC_W_L = sfspf_pkg::ACC_W;

    function automatic logic [CH_W-1:0] next_en(input logic [NCH-1:0] m, input logic [CH_W-1:0] c);
        logic [CH_W-1:0] r;
        int k;
        r = c;
        for (int i = NCH; i >= 1; i--) begin
            k = (int'(c) + i) % NCH;
            if (m[k]) begin
                r = k[CH_W-1:0];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Master clock tick
    // ------------------------------------------------------------
    // A phase accumulator gives the exact average master rate; the
    // tick jitters by one system clock, which the filter never sees.
    // MCLK_SCALE speeds every master rate up by the same factor; it is 1 in
    // the product and lets a bench cover many output periods in a short run.
    // The scaled increment must stay below half the accumulator range.
    logic [31:0] phase_ff, nxt_phase, inc;
    logic tick_ff, nxt_tick;

    always_comb begin
        inc = 32'(sfspf_pkg::mclk_inc(power_mode) * MCLK_SCALE);
        {nxt_tick, nxt_phase} = {1'b0, phase_ff} + {1'b0, inc};
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            tick_ff <= nxt_tick;
        end
    end

    assign mod_take = tick_ff;

    // ------------------------------------------------------------
    // Conversion control and sinc3 datapath
    // ------------------------------------------------------------
    sfspf_pkg::sfspf_state_t st_ff, nxt_st;
    logic [CFG_W-1:0] cfg_ff, nxt_cfg, cfg;
    logic [6:0] dead_ff, nxt_dead;
    logic [CH_W-1:0] chan_ff, nxt_chan;
    logic [15:0] dec_ff, nxt_dec, dec_top;
    logic [5:0] s3cnt_ff, nxt_s3cnt, s3n, blk, avg;
    logic [ACC_W_L-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff;
    logic [ACC_W_L-1:0] nxt_i1, nxt_i2, nxt_i3, nxt_d1, nxt_d2, nxt_d3, c1, c2, c3;
    logic [sfspf_pkg::SUM_W-1:0] sum_ff, nxt_sum, sum_new;
    logic res_valid_ff, nxt_res_valid;
    logic [sfspf_pkg::SUM_W-1:0] res_data_ff, nxt_res_data;
    logic [CH_W-1:0] res_chan_ff, nxt_res_chan;
    logic is_fast, is_post, multi;
    logic [10:0] rd_eff;

    assign cfg = {filt_type, post_sel, power_mode, rate_divider, chan_en};
    assign is_fast = (filt_type == sfspf_pkg::FT_FAST3);
    assign is_post = (filt_type == sfspf_pkg::FT_POST);
    assign multi = |(chan_en & (chan_en - NCH'(1)));
    assign avg = (power_mode == sfspf_pkg::PM_LOW) ? sfspf_pkg::AVG_LOW : sfspf_pkg::AVG_FULL;
    assign blk = is_post ? sfspf_pkg::post_len(post_sel) : avg;
    assign rd_eff = is_post ? sfspf_pkg::post_rd(power_mode) : rate_divider;
    assign dec_top = {rd_eff, 5'h0} - 16'h1;

    always_comb begin
        nxt_st = st_ff;
        nxt_cfg = cfg;
        nxt_dead = dead_ff;
        nxt_chan = chan_ff;
        nxt_dec = dec_ff;
        nxt_s3cnt = s3cnt_ff;
        nxt_i1 = i1_ff + {{(ACC_W_L-1){1'b0}}, mod_bit};
        nxt_i2 = i2_ff + i1_ff;
        nxt_i3 = i3_ff + i2_ff;
        c1 = nxt_i3 - d1_ff;
        c2 = c1 - d2_ff;
        c3 = c2 - d3_ff;
        s3n = s3cnt_ff + 6'h1;
        sum_new = sum_ff + {{(sfspf_pkg::SUM_W-ACC_W_L){1'b0}}, c3};
        nxt_d1 = d1_ff;
        nxt_d2 = d2_ff;
        nxt_d3 = d3_ff;
        nxt_sum = sum_ff;
        nxt_res_valid = 1'b0;
        nxt_res_data = res_data_ff;
        nxt_res_chan = res_chan_ff;
        if (st_ff != sfspf_pkg::ST_RUN || !tick_ff) begin
            nxt_i1 = i1_ff;
            nxt_i2 = i2_ff;
            nxt_i3 = i3_ff;
        end
        if (cfg != cfg_ff) begin
            // Any new setting, channel selection included, restarts like a manual change.
            nxt_chan = next_en(chan_en, CH_W'(NCH - 1));
            nxt_dead = sfspf_pkg::DEAD_MANUAL;
            nxt_st = ((is_fast || is_post) && |chan_en) ? sfspf_pkg::ST_DEAD : sfspf_pkg::ST_IDLE;
        end else begin
            unique case (st_ff)
                sfspf_pkg::ST_IDLE: begin
                end
                sfspf_pkg::ST_DEAD: begin
                    if (tick_ff) begin
                        nxt_dead = dead_ff - 7'h1;
                        if (dead_ff == 7'h1) begin
                            nxt_st = sfspf_pkg::ST_RUN;
                        end
                    end
                end
                sfspf_pkg::ST_RUN: begin
                    if (tick_ff) begin
                        nxt_dec = dec_ff + 16'h1;
                        if (dec_ff == dec_top) begin
                            nxt_dec = 16'h0;
                            nxt_d1 = nxt_i3;
                            nxt_d2 = c1;
                            nxt_d3 = c2;
                            nxt_s3cnt = s3n;
                            // The first sinc3 words after a start are partial and dropped.
                            if (s3n > sfspf_pkg::DISCARD) begin
                                nxt_sum = sum_new;
                            end
                            if (s3n == sfspf_pkg::DISCARD + blk) begin
                                nxt_res_valid = 1'b1;
                                nxt_res_data = sum_new;
                                nxt_res_chan = chan_ff;
                                nxt_sum = '0;
                                if (multi) begin
                                    nxt_st = sfspf_pkg::ST_DEAD;
                                    nxt_dead = sfspf_pkg::DEAD_SEQ;
                                    nxt_chan = next_en(chan_en, chan_ff);
                                end else if (is_post) begin
                                    nxt_s3cnt = sfspf_pkg::DISCARD;
                                end else begin
                                    nxt_s3cnt = 6'h0;
                                end
                            end
                        end
                    end
                end
                default: begin
                    nxt_st = sfspf_pkg::ST_IDLE;
                end
            endcase
        end
        // A fresh conversion starts from empty integrators and comb delays.
        if (nxt_st != sfspf_pkg::ST_RUN || (st_ff == sfspf_pkg::ST_RUN && nxt_res_valid && is_fast)) begin
            nxt_i1 = '0;
            nxt_i2 = '0;
            nxt_i3 = '0;
            nxt_d1 = '0;
            nxt_d2 = '0;
            nxt_d3 = '0;
            nxt_dec = 16'h0;
            if (!(nxt_res_valid && is_post && !multi)) begin
                nxt_s3cnt = 6'h0;
            end
            nxt_sum = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= sfspf_pkg::ST_IDLE;
            cfg_ff <= '0;
            dead_ff <= 7'h0;
            chan_ff <= '0;
            dec_ff <= 16'h0;
            s3cnt_ff <= 6'h0;
            i1_ff <= '0;
            i2_ff <= '0;
            i3_ff <= '0;
            d1_ff <= '0;
            d2_ff <= '0;
            d3_ff <= '0;
            sum_ff <= '0;
            res_valid_ff <= 1'b0;
            res_data_ff <= '0;
            res_chan_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
            dead_ff <= nxt_dead;
            chan_ff <= nxt_chan;
            dec_ff <= nxt_dec;
            s3cnt_ff <= nxt_s3cnt;
            i1_ff <= nxt_i1;
            i2_ff <= nxt_i2;
            i3_ff <= nxt_i3;
            d1_ff <= nxt_d1;
            d2_ff <= nxt_d2;
            d3_ff <= nxt_d3;
            sum_ff <= nxt_sum;
            res_valid_ff <= nxt_res_valid;
            res_data_ff <= nxt_res_data;
            res_chan_ff <= nxt_res_chan;
        end
    end

    logic busy_ff, nxt_busy;

    always_comb begin
        nxt_busy = (nxt_st != sfspf_pkg::ST_IDLE);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    assign busy = busy_ff;
    assign cur_chan = chan_ff;
    assign res_valid = res_valid_ff;
    assign res_data = res_data_ff;
    assign res_chan = res_chan_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_strobe_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff |=> !res_valid_ff)
        else $error("result strobe longer than one cycle");
    a_tick_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_ff |=> !tick_ff)
        else $error("master tick too fast");
    a_mode_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff |-> $past(is_fast || is_post))
        else $error("result in an unsupported filter mode");
    a_fast_avg: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff && $past(is_fast) |-> $past(s3cnt_ff) == $past(sfspf_pkg::DISCARD + avg - 6'h1))
        else $error("fast result not after discard plus average count");
    a_post_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff && $past(is_post) |-> $past(s3cnt_ff) == $past(sfspf_pkg::DISCARD + blk - 6'h1))
        else $error("post result at wrong sinc3 count");
    a_manual_dead: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg != cfg_ff) && (is_fast || is_post) && (|chan_en)
        |=> st_ff == sfspf_pkg::ST_DEAD && dead_ff == sfspf_pkg::DEAD_MANUAL)
        else $error("manual change without full dead time");
    a_seq_dead: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff && $past(multi) && $past(cfg == cfg_ff)
        |-> st_ff == sfspf_pkg::ST_DEAD && dead_ff == sfspf_pkg::DEAD_SEQ && chan_ff != res_chan_ff)
        else $error("sequencer did not advance with short dead time");
    a_single_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
        res_valid_ff && !$past(multi) && $past(cfg == cfg_ff)
        |-> st_ff == sfspf_pkg::ST_RUN && dec_ff == 16'h0
            && s3cnt_ff == ($past(is_post) ? sfspf_pkg::DISCARD : 6'h0))
        else $error("single channel did not continue converting");
    a_dec_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_ff == sfspf_pkg::ST_RUN && tick_ff && cfg == cfg_ff && dec_ff == dec_top |=> dec_ff == 16'h0)
        else $error("decimator period wrong");

endmodule

`default_nettype wire

// ==== bench/sfspf_mod_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module sfspf_mod_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Filter side
    input wire logic mod_take,
    input wire logic [3:0] cur_chan,
    output logic mod_bit,
    // Analog level seen by the modulator
    input wire logic [7:0] level
);
    logic [8:0] acc_ff;
    logic [8:0] nxt_acc;

    // ------------------------------------------------------------
    // Pulse density modulator
    // ------------------------------------------------------------
    // Each channel sees a different level, so a wrong channel mux changes the stream.
    always_comb begin
        nxt_acc = acc_ff;
        if (mod_take) begin
            nxt_acc = {1'b0, acc_ff[7:0]} + {1'b0, level ^ {cur_chan, cur_chan}};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_ff <= 9'h000;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // The bit is only valid in the take cycle; outside it the line shows the inverse.
    assign mod_bit = mod_take ? acc_ff[8] : ~acc_ff[8];
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    typedef struct {logic [3:0] chan; int ticks; int lvl;} sfspf_note_t;
    // Master ticks run this many times faster than in the product, to keep the run short.
    localparam int SCALE = 32;
    logic ref_clk, sys_rst, mod_bit, mod_take, busy, res_valid;
    logic [2:0] filt_type;
    logic [1:0] post_sel, power_mode;
    logic [10:0] rate_divider;
    logic [15:0] chan_en, en;
    logic [3:0] cur_chan, res_chan, low;
    logic [sfspf_pkg::SUM_W-1:0] res_data;
    logic [7:0] level;
    int n_mismatch, checked, tick_cnt, n_res, cyc, k, got;
    real span;
    bit arm;
    sfspf_note_t notes[$];
    sfspf_note_t note;
    real mclk_hz[3] = '{614400.0, 153600.0, 76800.0};
    logic [1:0] pm_code[3] = '{sfspf_pkg::PM_FULL, sfspf_pkg::PM_MID, sfspf_pkg::PM_LOW};

    sfspf_filter #(.NCH(16), .CH_W(4), .MCLK_SCALE(SCALE)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mod_bit(mod_bit), .mod_take(mod_take),
        .filt_type(filt_type), .post_sel(post_sel), .power_mode(power_mode),
        .rate_divider(rate_divider), .chan_en(chan_en), .busy(busy), .cur_chan(cur_chan),
        .res_valid(res_valid), .res_data(res_data), .res_chan(res_chan)
    );

    sfspf_mod_model mod_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mod_take(mod_take), .cur_chan(cur_chan),
        .mod_bit(mod_bit), .level(level)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cfg(input logic [2:0] ft, input logic [1:0] pm, input logic [10:0] rd,
                       input logic [15:0] ce, input logic [1:0] ps);
        @(posedge ref_clk);
        #1;
        filt_type = ft;
        power_mode = pm;
        rate_divider = rd;
        chan_en = ce;
        post_sel = ps;
        arm = 1'b1;
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Counts ref_clk cycles spanned by n master ticks, from one take pulse to the n-th after it.
    task automatic tick_span(input int n);
        k = 0;
        cyc = 0;
        while (k <= n && cyc < 60000) begin
            @(posedge ref_clk);
            #1;
            if (k > 0) cyc++;
            if (mod_take === 1'b1) k++;
        end
        if (k <= n) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    // Ticks are counted from the edge that takes a new setting, or from the last result.
    always @(posedge ref_clk) begin
        if (arm) begin
            arm = 1'b0;
            tick_cnt = 0;
        end else if (res_valid === 1'b1) begin
            n_res++;
            if (notes.size() == 0) begin
                chk("unexpected result", 1, 0);
            end else begin
                note = notes.pop_front();
                chk("res_chan", res_chan, note.chan);
                chk("ticks to result", tick_cnt, note.ticks);
                // Sixteen sinc3 words of gain 32**3 at a density of lvl/256 sum to about 2048*lvl.
                if (note.lvl >= 0) begin
                    got = int'(res_data >> 11);
                    chk("res_data level", (got >= note.lvl - 1) && (got <= note.lvl + 1), 1);
                end
            end
            tick_cnt = 0;
        end else if (mod_take === 1'b1) begin
            tick_cnt++;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        filt_type = 3'h0;
        post_sel = 2'h0;
        power_mode = 2'h0;
        rate_divider = 11'h001;
        chan_en = 16'h0000;
        level = 8'h40;
        arm = 1'b0;
        n_mismatch = 0;
        checked = 0;
        tick_cnt = 0;
        n_res = 0;
        void'($urandom(32'hb01782f9));
        repeat (4) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        chk("busy after reset", busy, 0);
        for (int i = 0; i < 3; i++) begin
            cfg(3'h5, pm_code[i], 11'h001, 16'h0001, 2'h0);
            tick_span(16);
            span = 16.0e8 / (mclk_hz[i] * SCALE);
            chk("master tick span", (cyc > span - 2.0) && (cyc < span + 2.0), 1);
        end
        cfg(3'h0, sfspf_pkg::PM_FULL, 11'h001, 16'h0001, 2'h0);
        settle();
        chk("busy unknown type", busy, 0);
        cfg(3'h5, sfspf_pkg::PM_FULL, 11'h001, 16'h0000, 2'h0);
        settle();
        chk("busy no channel", busy, 0);
        for (int ps = 0; ps < 4; ps++) begin
            en = 16'($urandom) | 16'h8000;
            for (int j = 15; j >= 0; j--) begin
                if (en[j]) low = 4'(j);
            end
            cfg(3'h7, sfspf_pkg::PM_FULL, 11'(($urandom % 2047) + 1), en, 2'(ps));
            settle();
            chk("busy post mode", busy, 1);
            chk("first post channel", cur_chan, low);
        end
        // Sequenced fast settling: first channel pays the long dead time, the next the short one.
        n_res = 0;
        notes.push_back('{4'h2, 94 + 18 * 32, 8'h40 ^ 8'h22});
        notes.push_back('{4'h9, 30 + 18 * 32, 8'h40 ^ 8'h99});
        cfg(3'h5, sfspf_pkg::PM_FULL, 11'h001, 16'h0204, 2'h0);
        k = 0;
        while (n_res < 2 && k < 20000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk("results seen", n_res, 2);
        // Single channel: a level step in mid conversion spoils one result only.
        n_res = 0;
        notes.push_back('{4'h0, 94 + 18 * 32, 8'h40});
        notes.push_back('{4'h0, 18 * 32, -1});
        cfg(3'h5, sfspf_pkg::PM_FULL, 11'h001, 16'h0001, 2'h0);
        k = 0;
        while (n_res < 3 && k < 30000) begin
            @(posedge ref_clk);
            #1;
            k++;
            if (n_res == 1 && notes.size() == 1 && tick_cnt == 200) begin
                level = 8'($urandom) | 8'h10;
                notes.push_back('{4'h0, 18 * 32, int'(level)});
            end
        end
        chk("single results", n_res, 3);
        chk("notes left", notes.size(), 0);
        wrap_up();
    end
endmodule

`default_nettype wire
